// File: lpws_pkg.sv
// package: register map, vector table, recovery counts and types of the wake sequencer
package lpws_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets) and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CFG    = 8'h00;   // configuration bits
  localparam logic [7:0] REG_KBD    = 8'h04;   // keypad polarity and enable
  localparam logic [7:0] REG_STATUS = 8'h08;   // sequencer state, read only
  localparam logic [7:0] REG_VECTOR = 8'h0C;   // last vector address, read only
  localparam logic [7:0] REG_RECCNT = 8'h10;   // recovery counter, read only

  localparam int CFG_SHORT_REC = 0;            // short_stop_recovery
  localparam int CFG_OSC_STOP  = 1;            // osc_runs_in_stop
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam logic [7:0] KBD_RESET = 8'h00;

  // ---------------------------------------------------------------
  // stop recovery counts, in crystal_clock cycles
  // ---------------------------------------------------------------
  localparam int REC_LONG_CYC  = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam logic [11:0] REC_LONG_LAST  = 12'(REC_LONG_CYC - 1);
  localparam logic [11:0] REC_SHORT_LAST = 12'(REC_SHORT_CYC - 1);

  // ---------------------------------------------------------------
  // vectors; interrupt requests are packed by priority, bit 24 first
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam int NUM_REQ = 25;
  localparam logic [NUM_REQ-1:0] REQ_BRK  = 25'h1000000;
  localparam logic [NUM_REQ-1:0] REQ_IRQ  = 25'h0800000;
  localparam logic [NUM_REQ-1:0] REQ_KBD  = 25'h0000400;
  localparam logic [NUM_REQ-1:0] REQ_TBM  = 25'h0000100;
  localparam logic [NUM_REQ-1:0] REQ_CANW = 25'h0000080;
  localparam logic [15:0] VEC_TAB [NUM_REQ-1:0] = '{
    16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0,
    16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2,
    16'hFFE0, 16'hFFDE, 16'hFFDC, 16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4,
    16'hFFD2, 16'hFFD0, 16'hFFCE, 16'hFFCC};

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_STOP, MODE_RECOVER} lpws_mode_e;

  // peripheral interrupt requests, in vector priority order
  typedef struct packed {
    logic clock_generator;    logic t1Ch0;  logic t1Ch1;  logic t1Ovf;
    logic t2Ch0;  logic t2Ch1;  logic t2Ovf;  logic spiRx;
    logic spiTx;  logic sciErr; logic sciRx;  logic sciTx;
    logic adc;    logic timebase_unit;    logic canWake; logic canErr;
    logic canRx;  logic canTx;  logic t2Ch2;  logic t2Ch3;
    logic t2Ch4;  logic t2Ch5;
  } lpws_periph_s;

  // clock and peripheral run controls
  typedef struct packed {
    logic cpuClkEn;  logic busClkEn;  logic xtalClkEn;
    logic spiRun;    logic timerRun;  logic tbmRun;
    logic tbmAccess; logic canRun;    logic canAccess;
  } lpws_ctrl_s;

endpackage

// File: lpws_sequencer.sv
// module: low-power wait/stop wake sequencer with stop recovery counter and AHB-Lite registers
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Operation
// - serial peripheral port runs in wait; its interrupts can end wait
// - serial port idle in stop, keeps state; reset exit aborts and resets it
// - timers run in wait, halt in stop keeping count, resume after wake
// - timebase register not accessible to CPU during wait or stop
// - timebase runs in stop only when osc_runs_in_stop is set
// - timebase rollover wakes from stop with vector FFDC
// - CAN runs in wait but its registers are not accessible then
// - CAN idle in stop; activity wakes; data ignored until synchronised
// - every wait exit restarts CPU clock and loads reset or interrupt vector
// - reset pin low, watchdog timeout or low supply load vector FFFE
// - falling edge on interrupt pin wakes wait or stop, vector FFFA
// - break in emulation mode ends wait or stop, vector FFFC
// - clock generator vector FFF8, keypad vector FFE0
// - first timer vectors FFF2 overflow, FFF4 channel 1, FFF6 channel 0
// - second timer vectors FFEC, FFEE, FFF0; channels 5..2 FFCC..FFD2
// - serial peripheral port vectors FFE8 transmit, FFEA receive
// - async serial port vectors FFE2, FFE4, FFE6
// - converter vector FFDE, timebase vector FFDC
// - CAN vectors FFD4, FFD6, FFD8, FFDA
// - only listed sources end stop; keypad polarity bit selects rising edge
// - 12-bit recovery counter holds clocks off 4096 cycles after stop wake
// - short_stop_recovery shrinks the recovery to 32 cycles
// - wait/stop clear interrupt mask; interrupt exit keeps it, reset sets it
// - without osc_runs_in_stop, stop holds all clock outputs low
// ---------------------------------------------------------------
module lpws_sequencer #(
  parameter int KB_PINS = 8
) (
  // clock and reset (clk is the crystal_clock)
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // CPU core
  input  wire logic                 waitExec,
  input  wire logic                 stopExec,
  output logic                      vecLoad,
  output logic [15:0]               vecAddr,
  output logic                      iMask,
  // reset sources
  input  wire logic                 rstPinN,
  input  wire logic                 copTimeout,
  input  wire logic                 lvrTrip,
  // interrupt sources
  input  wire logic                 irqPinN,
  input  wire logic [KB_PINS-1:0]   kbPins,
  input  wire logic                 brkReq,
  input  wire logic                 emulMode,
  input  wire logic                 canActivity,
  input  wire logic                 canSynced,
  input  wire lpws_pkg::lpws_periph_s perIrq,
  // clock and peripheral controls
  output lpws_pkg::lpws_ctrl_s      ctrl,
  output logic                      spiAbort,
  output logic                      canRxEn
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lpws_pkg::lpws_mode_e modeQ, modeD;
  logic [11:0]          recCntQ, recCntD;
  logic                 recShortQ, recShortD;
  logic [15:0]          vecQ, vecD;
  logic                 vecLoadQ, vecLoadD;
  logic                 iMaskQ, iMaskD;
  logic                 spiAbortQ, spiAbortD;
  logic                 canRxEnQ, canRxEnD;
  logic                 lastResetQ, lastResetD;
  logic                 irqPrevQ;
  logic [KB_PINS-1:0]   kbPrevQ;
  logic [1:0]           cfgQ;
  logic [KB_PINS-1:0]   kbPolQ, kbEnQ;
  logic                 wrPendQ;
  logic [7:0]           wrAddrQ;
  logic [31:0]          rdDataQ;

  // ---------------------------------------------------------------
  // wake source decode
  // ---------------------------------------------------------------
  wire logic shortRec = cfgQ[lpws_pkg::CFG_SHORT_REC];
  wire logic oscStop  = cfgQ[lpws_pkg::CFG_OSC_STOP];
  wire logic inRun    = (modeQ == lpws_pkg::MODE_RUN);
  wire logic inWait   = (modeQ == lpws_pkg::MODE_WAIT);
  wire logic inStop   = (modeQ == lpws_pkg::MODE_STOP);
  wire logic inRecov  = (modeQ == lpws_pkg::MODE_RECOVER);

  // any reset source; these outrank every interrupt
  wire logic resetReq = ~rstPinN | copTimeout | lvrTrip;
  // interrupt pin falls, pins are taken as synchronous
  wire logic irqEdge  = irqPrevQ & ~irqPinN;
  // keypad edge per pin: rising when polarity set, falling otherwise
  wire logic [KB_PINS-1:0] kbRise = ~kbPrevQ & kbPins;
  wire logic [KB_PINS-1:0] kbFall = kbPrevQ & ~kbPins;
  wire logic kbdEdge  = |(kbEnQ & ((kbPolQ & kbRise) | (~kbPolQ & kbFall)));
  // break only counts in emulation mode
  wire logic brkWake  = brkReq & emulMode;
  // bus activity stands for the CAN wakeup request while stopped
  wire logic canWake  = perIrq.canWake | (canActivity & inStop);

  // all requests packed by vector priority, highest at the top
  wire logic [lpws_pkg::NUM_REQ-1:0] reqVec = {
    brkWake, irqEdge, perIrq.clock_generator,
    perIrq.t1Ch0, perIrq.t1Ch1, perIrq.t1Ovf,
    perIrq.t2Ch0, perIrq.t2Ch1, perIrq.t2Ovf,
    perIrq.spiRx, perIrq.spiTx,
    perIrq.sciErr, perIrq.sciRx, perIrq.sciTx,
    kbdEdge, perIrq.adc, perIrq.timebase_unit,
    canWake, perIrq.canErr, perIrq.canRx, perIrq.canTx,
    perIrq.t2Ch2, perIrq.t2Ch3, perIrq.t2Ch4, perIrq.t2Ch5};

  // stop honours only its short list; timebase only while oscillator runs
  wire logic [lpws_pkg::NUM_REQ-1:0] stopMask =
    lpws_pkg::REQ_BRK | lpws_pkg::REQ_IRQ | lpws_pkg::REQ_KBD |
    lpws_pkg::REQ_CANW | (oscStop ? lpws_pkg::REQ_TBM : '0);
  wire logic [lpws_pkg::NUM_REQ-1:0] stopReq = reqVec & stopMask;
  wire logic waitWake = |reqVec;
  wire logic stopWake = |stopReq;

  // ---------------------------------------------------------------
  // priority pick of the vector for the winning request
  // ---------------------------------------------------------------
  logic [15:0] waitVec, stopVec;
  always_comb begin
    waitVec = lpws_pkg::VEC_RESET;
    stopVec = lpws_pkg::VEC_RESET;
    // ascending scan, so the last hit is the highest priority
    for (int i = 0; i < lpws_pkg::NUM_REQ; i++) begin
      if (reqVec[i]) begin
        waitVec = lpws_pkg::VEC_TAB[i];
      end
      if (stopReq[i]) begin
        stopVec = lpws_pkg::VEC_TAB[i];
      end
    end
  end

  // terminal count follows the recovery length caught at the wake
  wire logic [11:0] recLast =
    recShortQ ? lpws_pkg::REC_SHORT_LAST : lpws_pkg::REC_LONG_LAST;
  wire logic recDone = inRecov & (recCntQ == recLast);

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  always_comb begin
    modeD      = modeQ;
    recCntD    = recCntQ;
    recShortD  = recShortQ;
    vecD       = vecQ;
    vecLoadD   = 1'b0;
    iMaskD     = iMaskQ;
    spiAbortD  = 1'b0;
    lastResetD = lastResetQ;
    case (modeQ)
      lpws_pkg::MODE_RUN: begin
        if (resetReq) begin
          vecD       = lpws_pkg::VEC_RESET;
          vecLoadD   = 1'b1;
          iMaskD     = 1'b1;
          lastResetD = 1'b1;
        end else if (stopExec) begin
          modeD  = lpws_pkg::MODE_STOP;
          iMaskD = 1'b0;
        end else if (waitExec) begin
          modeD  = lpws_pkg::MODE_WAIT;
          iMaskD = 1'b0;
        end
      end
      lpws_pkg::MODE_WAIT: begin
        if (resetReq) begin
          modeD      = lpws_pkg::MODE_RUN;
          vecD       = lpws_pkg::VEC_RESET;
          vecLoadD   = 1'b1;
          iMaskD     = 1'b1;
          lastResetD = 1'b1;
        end else if (waitWake) begin
          modeD      = lpws_pkg::MODE_RUN;
          vecD       = waitVec;
          vecLoadD   = 1'b1;
          lastResetD = 1'b0;
        end
      end
      lpws_pkg::MODE_STOP: begin
        // the recovery length is caught here so a late write cannot stretch it
        if (resetReq) begin
          modeD      = lpws_pkg::MODE_RECOVER;
          vecD       = lpws_pkg::VEC_RESET;
          iMaskD     = 1'b1;
          spiAbortD  = 1'b1;
          lastResetD = 1'b1;
          recCntD    = '0;
          recShortD  = shortRec;
        end else if (stopWake) begin
          modeD      = lpws_pkg::MODE_RECOVER;
          vecD       = stopVec;
          lastResetD = 1'b0;
          recCntD    = '0;
          recShortD  = shortRec;
        end
      end
      lpws_pkg::MODE_RECOVER: begin
        if (resetReq) begin
          vecD       = lpws_pkg::VEC_RESET;
          iMaskD     = 1'b1;
          lastResetD = 1'b1;
        end
        if (recDone) begin
          modeD    = lpws_pkg::MODE_RUN;
          vecLoadD = 1'b1;
        end else begin
          recCntD = recCntQ + 12'h001;
        end
      end
      default: begin
        modeD = lpws_pkg::MODE_RUN;
      end
    endcase
  end

  // CAN receive gate drops in stop and reopens only once resynchronised
  always_comb begin
    canRxEnD = canRxEnQ;
    if (inStop || inRecov) begin
      canRxEnD = 1'b0;
    end else if (inRun && canSynced) begin
      canRxEnD = 1'b1;
    end
  end

  // sequencer flops
  always_ff @(posedge clk) begin
    if (rst) begin
      modeQ      <= lpws_pkg::MODE_RUN;
      recCntQ    <= '0;
      recShortQ  <= 1'b0;
      vecQ       <= lpws_pkg::VEC_RESET;
      vecLoadQ   <= 1'b0;
      iMaskQ     <= 1'b1;
      spiAbortQ  <= 1'b0;
      canRxEnQ   <= 1'b0;
      lastResetQ <= 1'b1;
    end else begin
      modeQ      <= modeD;
      recCntQ    <= recCntD;
      recShortQ  <= recShortD;
      vecQ       <= vecD;
      vecLoadQ   <= vecLoadD;
      iMaskQ     <= iMaskD;
      spiAbortQ  <= spiAbortD;
      canRxEnQ   <= canRxEnD;
      lastResetQ <= lastResetD;
    end
  end

  // previous pin levels for edge detection; interrupt pin idles high
  always_ff @(posedge clk) begin
    if (rst) begin
      irqPrevQ <= 1'b1;
      kbPrevQ  <= '0;
    end else begin
      irqPrevQ <= irqPinN;
      kbPrevQ  <= kbPins;
    end
  end

  // ---------------------------------------------------------------
  // clock and peripheral controls
  // ---------------------------------------------------------------
  // stop without running oscillator gates every clock output low
  assign ctrl.cpuClkEn  = inRun;
  assign ctrl.busClkEn  = inRun | inWait | (inStop & oscStop);
  assign ctrl.xtalClkEn = ~(inStop & ~oscStop);
  assign ctrl.spiRun    = inRun | inWait;
  assign ctrl.timerRun  = inRun | inWait;
  assign ctrl.tbmRun    = inRun | inWait | (inStop & oscStop);
  assign ctrl.tbmAccess = inRun;
  assign ctrl.canRun    = inRun | inWait;
  assign ctrl.canAccess = inRun;
  assign vecLoad        = vecLoadQ;
  assign vecAddr        = vecQ;
  assign iMask          = iMaskQ;
  assign spiAbort       = spiAbortQ;
  assign canRxEn        = canRxEnQ;

  // ---------------------------------------------------------------
  // AHB-Lite register slave
  // ---------------------------------------------------------------
  // zero wait states; hsize is not checked, only whole words are expected
  wire logic       addrPhase = hsel & htrans[1] & hready;
  wire logic [7:0] regAddr   = haddr[7:0];
  wire logic [31:0] statusWord = {26'h0, lastResetQ, canRxEnQ, inRecov, iMaskQ, modeQ};
  logic [31:0] rdMux;
  always_comb begin
    case (regAddr)
      lpws_pkg::REG_CFG:    rdMux = {30'h0, cfgQ};
      lpws_pkg::REG_KBD:    rdMux = {16'h0, 8'(kbEnQ), 8'(kbPolQ)};
      lpws_pkg::REG_STATUS: rdMux = statusWord;
      lpws_pkg::REG_VECTOR: rdMux = {16'h0, vecQ};
      lpws_pkg::REG_RECCNT: rdMux = {20'h0, recCntQ};
      default:              rdMux = 32'h0;
    endcase
  end

  // address phase capture and read data launch
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPendQ <= 1'b0;
      wrAddrQ <= 8'h00;
      rdDataQ <= 32'h0;
    end else begin
      wrPendQ <= addrPhase & hwrite;
      wrAddrQ <= regAddr;
      if (addrPhase && !hwrite) begin
        rdDataQ <= rdMux;
      end
    end
  end

  // data phase writes; unmapped offsets are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgQ   <= lpws_pkg::CFG_RESET;
      kbPolQ <= KB_PINS'(lpws_pkg::KBD_RESET);
      kbEnQ  <= KB_PINS'(lpws_pkg::KBD_RESET);
    end else if (wrPendQ) begin
      if (wrAddrQ == lpws_pkg::REG_CFG) begin
        cfgQ <= hwdata[1:0];
      end
      if (wrAddrQ == lpws_pkg::REG_KBD) begin
        kbPolQ <= hwdata[KB_PINS-1:0];
        kbEnQ  <= hwdata[KB_PINS+7:8];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdDataQ;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_resetVec;
    @(posedge clk) disable iff (rst)
    (resetReq && (inRun || inWait)) |=> (vecLoad && vecAddr == lpws_pkg::VEC_RESET && iMask);
  endproperty
  a_resetVec: assert property (p_resetVec) else $error("reset source did not load reset vector");

  property p_stopClocks;
    @(posedge clk) disable iff (rst)
    (inStop && !oscStop) |-> (!ctrl.xtalClkEn && !ctrl.busClkEn && !ctrl.cpuClkEn);
  endproperty
  a_stopClocks: assert property (p_stopClocks) else $error("clocks running in stop");

  property p_maskClear;
    @(posedge clk) disable iff (rst)
    (inRun && !resetReq && (waitExec || stopExec)) |=> (!iMask && !inRun);
  endproperty
  a_maskClear: assert property (p_maskClear) else $error("mask not cleared on sleep entry");

  property p_shortRec;
    @(posedge clk) disable iff (rst)
    (inStop && stopWake && !resetReq && shortRec) |=>
      ##31 (inRecov && recCntQ == lpws_pkg::REC_SHORT_LAST && !vecLoad) ##1 (vecLoad && inRun);
  endproperty
  a_shortRec: assert property (p_shortRec) else $error("short recovery length wrong");

  property p_recHold;
    @(posedge clk) disable iff (rst)
    inRecov |-> (!ctrl.cpuClkEn && !ctrl.busClkEn && recCntQ <= recLast);
  endproperty
  a_recHold: assert property (p_recHold) else $error("clocks released during recovery");

  property p_recRelease;
    @(posedge clk) disable iff (rst)
    (inRecov && recCntQ == lpws_pkg::REC_LONG_LAST) |=> (ctrl.cpuClkEn && ctrl.busClkEn && vecLoad);
  endproperty
  a_recRelease: assert property (p_recRelease) else $error("long recovery did not release");

  property p_noAccess;
    @(posedge clk) disable iff (rst)
    (inWait || inStop) |-> (!ctrl.tbmAccess && !ctrl.canAccess);
  endproperty
  a_noAccess: assert property (p_noAccess) else $error("register access open while asleep");

  property p_waitRun;
    @(posedge clk) disable iff (rst)
    inWait |-> (ctrl.canRun && ctrl.spiRun && ctrl.timerRun && ctrl.tbmRun);
  endproperty
  a_waitRun: assert property (p_waitRun) else $error("peripheral halted in wait");

  property p_stopHalt;
    @(posedge clk) disable iff (rst)
    inStop |-> (!ctrl.timerRun && !ctrl.spiRun && ctrl.tbmRun == oscStop);
  endproperty
  a_stopHalt: assert property (p_stopHalt) else $error("stop run controls wrong");

  property p_irqWake;
    @(posedge clk) disable iff (rst)
    (inWait && irqEdge && !resetReq && !brkWake) |=> (vecLoad && vecAddr == 16'hFFFA);
  endproperty
  a_irqWake: assert property (p_irqWake) else $error("interrupt pin wake vector wrong");

  property p_stopStays;
    @(posedge clk) disable iff (rst)
    (inStop && !stopWake && !resetReq) |=> inStop;
  endproperty
  a_stopStays: assert property (p_stopStays) else $error("stop left without a stop source");

  property p_spiAbort;
    @(posedge clk) disable iff (rst)
    (inStop && resetReq) |=> (spiAbort && inRecov) ##1 !spiAbort;
  endproperty
  a_spiAbort: assert property (p_spiAbort) else $error("serial port not aborted on reset exit");

  property p_canGate;
    @(posedge clk) disable iff (rst)
    $fell(inRecov) |-> !canRxEn;
  endproperty
  a_canGate: assert property (p_canGate) else $error("CAN receive open before sync");

endmodule // lpws_sequencer

// File: lpws_cpu_model.sv
// partner model of the cpu core: issues wait and stop instructions
`timescale 1ns/10ps
module lpws_cpu_model (
  // clock
  input  wire logic clk,
  // sleep instructions toward the sequencer
  output logic      waitExec,
  output logic      stopExec
);
  // a real core never raises both at once
  initial begin
    waitExec = 1'h0;
    stopExec = 1'h0;
  end
  // one-cycle instruction pulse, changed only just after an edge
  task automatic sleep(input bit stp);
    @(posedge clk);
    waitExec <= !stp;
    stopExec <= stp;
    @(posedge clk);
    waitExec <= 1'h0;
    stopExec <= 1'h0;
  endtask
endmodule // lpws_cpu_model

// File: lpws_sequencer_test.sv
// testbench: sleep entry, wake sources, vectors and stop recovery timing
`timescale 1ns/10ps
module lpws_sequencer_test;
  logic                   clk, rst, hsel, hwrite, hreadyout, hresp, vecLoad, iMask, sawAbort;
  logic                   waitExec, stopExec, rstPinN, copTimeout, lvrTrip, irqPinN;
  logic                   brkReq, emulMode, canActivity, canSynced, spiAbort, canRxEn;
  logic [1:0]             htrans;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [15:0]            vecAddr;
  logic [7:0]             kbPins;
  lpws_pkg::lpws_periph_s perIrq;
  lpws_pkg::lpws_ctrl_s   ctrl;
  int                     error_cnt, checks, n;
  // expected vectors of the peripheral requests, top bit first
  logic [15:0]            vt [22] = '{16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0,
    16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFDE, 16'hFFDC,
    16'hFFDA, 16'hFFD8, 16'hFFD6, 16'hFFD4, 16'hFFD2, 16'hFFD0, 16'hFFCE, 16'hFFCC};

  lpws_sequencer DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .waitExec, .stopExec, .vecLoad, .vecAddr,
    .iMask, .rstPinN, .copTimeout, .lvrTrip, .irqPinN, .kbPins, .brkReq, .emulMode,
    .canActivity, .canSynced, .perIrq, .ctrl, .spiAbort, .canRxEn);
  lpws_cpu_model cpu (.clk, .waitExec, .stopExec);

  // free-running 100 MHz clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // bounded wait for hready sampled high at an edge
  task automatic wt;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (hreadyout === 1'h1) break;
    end
    if (n == 100) begin
      error_cnt++;
      finish_test();
    end
  endtask

  // single word transfer; read data taken at the end of the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    wt();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wt();
    rd = hrdata;
    chk("hresp", hresp, 32'h0);
  endtask

  // sleep, then judge the clock and run controls while asleep
  task automatic nap(input bit stp, input logic [8:0] expC);
    cpu.sleep(stp);
    #1;
    chk("sleep ctrl", ctrl, expC);
    chk("sleep mask", iMask, 32'h0);
    @(posedge clk);
  endtask

  // count cycles from the request edge to the vector load
  task automatic waitVec(input int expN, input logic [15:0] expV, input logic expM);
    sawAbort = 1'h0;
    for (n = 1; n <= 5000; n++) begin
      @(posedge clk);
      #1;
      sawAbort = sawAbort | (spiAbort === 1'h1);
      if (vecLoad === 1'h1) break;
    end
    if (n > 5000) begin
      error_cnt++;
      finish_test();
    end
    chk("latency", n, expN);
    chk("vector", vecAddr, expV);
    chk("wake mask", iMask, expM);
    chk("run ctrl", ctrl, 9'h1FF);
  endtask

  // reset state and register access, unmapped offset included
  task automatic t_regs;
    chk("reset vector", vecAddr, 16'hFFFE);
    chk("reset mask", iMask, 1'h1);
    ahb(1'h0, lpws_pkg::REG_STATUS, 32'h0);
    chk("status", rd, 32'h24);
    ahb(1'h0, lpws_pkg::REG_VECTOR, 32'h0);
    chk("vector reg", rd, 32'hFFFE);
    ahb(1'h0, lpws_pkg::REG_CFG, 32'h0);
    chk("cfg", rd, 32'h0);
    ahb(1'h0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'h1, lpws_pkg::REG_KBD, 32'h0101);
    ahb(1'h0, lpws_pkg::REG_KBD, 32'h0);
    chk("keypad", rd, 32'h0101);
  endtask

  // each peripheral request and each reset source ends wait
  task automatic t_wait;
    for (int i = 0; i < 26; i++) begin
      nap(1'h0, 9'h0FA);
      perIrq <= lpws_pkg::lpws_periph_s'((i < 22) ? 22'h1 << (21 - i) : 22'h0);
      rstPinN <= (i != 22);
      copTimeout <= (i == 23);
      lvrTrip <= (i == 24);
      irqPinN <= (i != 25);
      waitVec(1, (i < 22) ? vt[i] : ((i == 25) ? 16'hFFFA : 16'hFFFE), i > 21 && i < 25);
      @(posedge clk);
      perIrq <= '0;
      rstPinN <= 1'h1;
      copTimeout <= 1'h0;
      lvrTrip <= 1'h0;
      irqPinN <= 1'h1;
    end
  endtask

  // stop: refused requests first, then one wake source (reset pin with interrupt pin fall for s 4), then recovery
  task automatic stopWake(input int s, input logic [1:0] cfg, input logic [15:0] v,
                          input logic m);
    ahb(1'h1, lpws_pkg::REG_CFG, {30'h0, cfg});
    nap(1'h1, cfg[1] ? 9'h0C8 : 9'h000);
    perIrq <= lpws_pkg::lpws_periph_s'(22'h3FFE7F);
    brkReq <= 1'h1;
    repeat (3) begin
      @(posedge clk);
      #1;
      chk("refused", {vecLoad, ctrl}, {1'h0, (cfg[1] ? 9'h0C8 : 9'h000)});
    end
    @(posedge clk);
    perIrq <= lpws_pkg::lpws_periph_s'((s == 2) ? 22'h000100 : 22'h0);
    brkReq <= (s == 5);
    emulMode <= (s == 5);
    irqPinN <= !(s == 0 || s == 4);
    kbPins <= (s == 1) ? 8'h01 : 8'h00;
    canActivity <= (s == 3);
    rstPinN <= (s != 4);
    waitVec((cfg[0] ? lpws_pkg::REC_SHORT_CYC : lpws_pkg::REC_LONG_CYC) + 1, v, m);
    chk("abort", sawAbort, s == 4);
    chk("can rx", canRxEn, 1'h0);
    @(posedge clk);
    {irqPinN, rstPinN, canSynced} <= {2'h3, s == 3};
    {kbPins, perIrq, canActivity, brkReq, emulMode} <= '0;
    repeat (2) @(posedge clk);
    #1;
    chk("can sync", canRxEn, s == 3);
  endtask

  initial begin
    {rst, rstPinN, irqPinN} = 3'h7;
    {hsel, hwrite, htrans, haddr, hwdata, kbPins, perIrq} = '0;
    {copTimeout, lvrTrip, brkReq, emulMode, canActivity, canSynced} = '0;
    error_cnt = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_wait();
    stopWake(0, 2'h0, 16'hFFFA, 1'h0);
    stopWake(1, 2'h3, 16'hFFE0, 1'h0);
    stopWake(2, 2'h3, 16'hFFDC, 1'h0);
    stopWake(4, 2'h3, 16'hFFFE, 1'h1);
    stopWake(5, 2'h3, 16'hFFFC, 1'h0);
    stopWake(3, 2'h0, 16'hFFDA, 1'h0);
    finish_test();
  end
endmodule // lpws_sequencer_test
